// ---- hdl/itms_map.svh ----
`ifndef ITMS_MAP_SVH
`define ITMS_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ITMS_OFF_MIN_INTERVAL 12'h0C4
`define ITMS_OFF_CAUSE_FORCE 12'h0C8
`define ITMS_OFF_CAUSE_READ 12'h0C0
`define ITMS_OFF_ENABLE_SET 12'h0D0
`define ITMS_OFF_ENABLE_CLEAR 12'h0D8
`define ITMS_OFF_AUTO_MASK 12'h0E0
`define ITMS_OFF_EXT_CONTROL 12'h018

// ****************************************************************
// Field positions and values
// ****************************************************************
`define ITMS_INTERVAL_W 16
`define ITMS_CAUSE_VALID_MASK 32'h0153_82D7
`define ITMS_ASSERTED_BIT 31
`define ITMS_OTHER_BIT 24
`define ITMS_OTHER_SRC_MASK 32'h0003_0244
`define ITMS_EXT_AUTO_MASK_BIT 0
`define ITMS_EXT_TIMERS_CLEAR_BIT 1
`define ITMS_ALL_ONES 32'hFFFF_FFFF
`define ITMS_ZERO32 32'h0000_0000
`define ITMS_INTERVAL_RESET 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define ITMS_CLK_PERIOD_NS 5
`define ITMS_TICK_NS 256
`define ITMS_TICK_CYCLES ((`ITMS_TICK_NS + `ITMS_CLK_PERIOD_NS - 1) / `ITMS_CLK_PERIOD_NS)

// ****************************************************************
// Bus response codes
// ****************************************************************
`define ITMS_RESP_OKAY 2'b00
`define ITMS_RESP_SLVERR 2'b10

`endif

// ---- hdl/itms_pkg.sv ----
`default_nettype none
package itms_pkg;
  // Throttle states, one-hot
  typedef enum logic [2:0]
  {
    ITMS_IDLE = 3'b001,
    ITMS_HOLD = 3'b010,
    ITMS_FIRE = 3'b100
  } itms_state_t;

  typedef logic [31:0] itms_word_t;
endpackage
`default_nettype wire

// ---- hdl/itms_tick_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Tick divider to throttle: clear request and tick
interface itms_tick_if;
  logic restart;
  logic tick;
  modport divider (input restart, output tick);
  modport user (output restart, input tick);
endinterface
`default_nettype wire

// ---- hdl/itms_tick_div.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "itms_map.svh"
module itms_tick_div
#(
  parameter int unsigned TICK_CYCLES = `ITMS_TICK_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  itms_tick_if.divider tk
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // Divide core clock by TICK_CYCLES, 52 cycles (260 ns, 256 ns rounded up) by default; restart realigns the phase
  always_comb
  begin
    cnt_next = cnt_reg + CW'(1);
    tick_next = 1'b0;
    if (tk.restart)
    begin
      cnt_next = '0;
    end
    else if (cnt_reg == CW'(TICK_CYCLES - 1))
    begin
      cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tk.tick = tick_reg;
endmodule
`default_nettype wire

// ---- hdl/itms_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "itms_map.svh"
// Summary of operation
// [RULE1] Throttle register low 16 bits hold interval in 256 ns units.
// [RULE2] Interval resets to zero; zero means no spacing enforced.
// [RULE3] Nonzero interval: no new interrupt before interval since last.
// [RULE4] Software writes zero to throttle upper bits; they read zero.
// [RULE5] Software should start tuning between 651 and 5580.
// [RULE6] Writing one to cause-force sets that cause bit.
// [RULE7] Zero bits leave causes unchanged; cause-force is write-only.
// [RULE8] Forced cause raises interrupt when its enable bit is set.
// [RULE9] Cause bits 0,1,2,4,6,7,9 as listed.
// [RULE10] Cause bits 15,16,17,20,22,24 as listed; others reserved.
// [RULE11] Reading enable register returns every enable bit.
// [RULE12] Interrupt only when a cause and its enable are both set.
// [RULE13] Writing one sets an enable bit; zero keeps it.
// [RULE14] Software disables interrupts through the enable-clear register.
// [RULE15] With timers-clear enabled, all-ones enable write resets delay timers.
// [RULE16] All enable bits reset to zero.
// [RULE17] Write one to cause-read clears bit; summary clears when all clear.
// [RULE18] Cause read clears if masks zero, or asserted with auto-mask.
// [RULE19] Writing one to enable-clear clears that enable bit.
// [RULE20] During interval enabled causes wait; fire at expiry, restart timer.
// [RULE21] Timer counts 256 ns ticks from divided clock against interval.
module itms_top
#(
  parameter int unsigned TICK_CYCLES = `ITMS_TICK_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output itms_pkg::itms_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] event_in,
  output logic host_irq,
  output logic delay_timers_clear
);
  import itms_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  itms_word_t rdata_reg, rdata_next;
  logic [15:0] interval_reg, interval_next;
  itms_word_t cause_reg, cause_next;
  itms_word_t enable_reg, enable_next;
  itms_word_t automask_reg, automask_next;
  logic [1:0] extctl_reg, extctl_next;
  logic [15:0] elapsed_reg, elapsed_next;
  itms_state_t state_reg, state_next;
  logic irq_reg, irq_next;
  logic tclr_reg, tclr_next;
  logic wr_go;
  logic rd_go;
  logic wr_map;
  logic rd_map;
  logic pend;
  itms_word_t wmask;
  itms_word_t wval;
  itms_word_t cause_vis;

  itms_tick_if tk ();

  itms_tick_div #(.TICK_CYCLES(TICK_CYCLES)) u_div
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk)
  );

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Write goes once both halves are held and no response is waiting
  assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_go = s_axi_arvalid && !rvalid_reg;
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // Byte lanes to bit mask
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
    end
    wval = wdata_reg & wmask;
  end

  // Summary bit is derived so it clears exactly when every cause clears
  // [RULE17] summary tracking
  assign cause_vis = {(cause_reg != `ITMS_ZERO32), cause_reg[30:0]};

  // Address decode for both directions
  always_comb
  begin
    case (awaddr_reg)
      `ITMS_OFF_MIN_INTERVAL, `ITMS_OFF_CAUSE_FORCE, `ITMS_OFF_CAUSE_READ,
      `ITMS_OFF_ENABLE_SET, `ITMS_OFF_ENABLE_CLEAR, `ITMS_OFF_AUTO_MASK,
      `ITMS_OFF_EXT_CONTROL: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
    case (s_axi_araddr)
      `ITMS_OFF_MIN_INTERVAL, `ITMS_OFF_CAUSE_FORCE, `ITMS_OFF_CAUSE_READ,
      `ITMS_OFF_ENABLE_SET, `ITMS_OFF_ENABLE_CLEAR, `ITMS_OFF_AUTO_MASK,
      `ITMS_OFF_EXT_CONTROL: rd_map = 1'b1;
      default: rd_map = 1'b0;
    endcase
  end

  // Bus channel state
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && !aw_held_reg)
    begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg)
    begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_map ? `ITMS_RESP_OKAY : `ITMS_RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (rd_go)
    begin
      rvalid_next = 1'b1;
      rresp_next = rd_map ? `ITMS_RESP_OKAY : `ITMS_RESP_SLVERR;
      case (s_axi_araddr)
        // [RULE4] upper bits read zero
        `ITMS_OFF_MIN_INTERVAL: rdata_next = {16'h0000, interval_reg};
        `ITMS_OFF_CAUSE_READ: rdata_next = cause_vis;
        // [RULE11] enable readback
        `ITMS_OFF_ENABLE_SET: rdata_next = enable_reg;
        `ITMS_OFF_AUTO_MASK: rdata_next = automask_reg;
        `ITMS_OFF_EXT_CONTROL: rdata_next = {30'h0000_0000, extctl_reg};
        // [RULE7] cause-force and enable-clear are write-only
        default: rdata_next = `ITMS_ZERO32;
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt registers
  // ****************************************************************
  // Event sets beat clears in the same cycle
  always_comb
  begin
    interval_next = interval_reg;
    automask_next = automask_reg;
    extctl_next = extctl_reg;
    enable_next = enable_reg;
    tclr_next = 1'b0;
    cause_next = cause_reg;
    if (wr_go && wr_map)
    begin
      case (awaddr_reg)
        // [RULE1] interval field
        `ITMS_OFF_MIN_INTERVAL: interval_next = (interval_reg & ~wmask[15:0]) | wval[15:0];
        `ITMS_OFF_AUTO_MASK: automask_next = (automask_reg & ~wmask) | wval;
        `ITMS_OFF_EXT_CONTROL: extctl_next = (extctl_reg & ~wmask[1:0]) | wval[1:0];
        // [RULE13] write one sets
        `ITMS_OFF_ENABLE_SET:
        begin
          enable_next = enable_reg | (wval & `ITMS_CAUSE_VALID_MASK);
          // [RULE15] all-ones clears timers
          tclr_next = extctl_reg[`ITMS_EXT_TIMERS_CLEAR_BIT] && (wval == `ITMS_ALL_ONES);
        end
        // [RULE19] write one clears enable
        `ITMS_OFF_ENABLE_CLEAR: enable_next = enable_reg & ~wval;
        // [RULE17] write one clears cause
        `ITMS_OFF_CAUSE_READ:
        begin
          cause_next = cause_reg & ~wval;
          if (irq_reg && extctl_reg[`ITMS_EXT_AUTO_MASK_BIT])
          begin
            enable_next = enable_reg & ~automask_reg;
          end
        end
        default: ;
      endcase
    end
    // [RULE18] read side effects
    if (rd_go && s_axi_araddr == `ITMS_OFF_CAUSE_READ)
    begin
      if (enable_reg == `ITMS_ZERO32)
      begin
        cause_next = `ITMS_ZERO32;
      end
      else if (irq_reg && extctl_reg[`ITMS_EXT_AUTO_MASK_BIT])
      begin
        cause_next = `ITMS_ZERO32;
        enable_next = enable_next & ~automask_reg;
      end
    end
    // [RULE6] forced causes act as events
    if (wr_go && wr_map && awaddr_reg == `ITMS_OFF_CAUSE_FORCE)
    begin
      cause_next = cause_next | wval;
    end
    // [RULE9] [RULE10] only defined positions hold
    cause_next = (cause_next | event_in) & `ITMS_CAUSE_VALID_MASK;
    if ((cause_next & `ITMS_OTHER_SRC_MASK) != `ITMS_ZERO32)
    begin
      cause_next[`ITMS_OTHER_BIT] = 1'b1;
    end
  end

  // ****************************************************************
  // Throttle
  // ****************************************************************
  // [RULE12] cause and enable both set
  assign pend = (cause_reg & enable_reg) != `ITMS_ZERO32;
  assign tk.restart = (state_next == ITMS_FIRE);

  // Interrupt line stays up while an enabled cause stays pending
  always_comb
  begin
    state_next = state_reg;
    elapsed_next = elapsed_reg;
    irq_next = irq_reg && pend;
    case (state_reg)
      ITMS_IDLE:
      begin
        // [RULE8] [RULE2] fire at once when idle
        if (pend && !irq_reg)
        begin
          state_next = ITMS_FIRE;
        end
      end
      ITMS_FIRE:
      begin
        irq_next = 1'b1;
        elapsed_next = 16'h0000;
        state_next = (interval_reg == `ITMS_INTERVAL_RESET) ? ITMS_IDLE : ITMS_HOLD;
      end
      ITMS_HOLD:
      begin
        // [RULE21] count ticks against interval
        if (tk.tick)
        begin
          elapsed_next = elapsed_reg + 16'h0001;
        end
        // [RULE3] [RULE20] wait then fire if still pending
        if (elapsed_reg >= interval_reg || tclr_reg)
        begin
          state_next = (pend && !irq_reg) ? ITMS_FIRE : ITMS_IDLE;
        end
      end
      default: state_next = ITMS_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= `ITMS_ZERO32;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ITMS_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `ITMS_RESP_OKAY;
      rdata_reg <= `ITMS_ZERO32;
      // [RULE2] [RULE16] reset values
      interval_reg <= `ITMS_INTERVAL_RESET;
      cause_reg <= `ITMS_ZERO32;
      enable_reg <= `ITMS_ZERO32;
      automask_reg <= `ITMS_ZERO32;
      extctl_reg <= 2'b00;
      elapsed_reg <= 16'h0000;
      state_reg <= ITMS_IDLE;
      irq_reg <= 1'b0;
      tclr_reg <= 1'b0;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      interval_reg <= interval_next;
      cause_reg <= cause_next;
      enable_reg <= enable_next;
      automask_reg <= automask_next;
      extctl_reg <= extctl_next;
      elapsed_reg <= elapsed_next;
      state_reg <= state_next;
      irq_reg <= irq_next;
      tclr_reg <= tclr_next;
    end
  end

  assign host_irq = irq_reg;
  assign delay_timers_clear = tclr_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence fire_seq;
    state_reg == ITMS_FIRE;
  endsequence

  AST_IRQ_NEEDS_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE12]
    $rose(irq_reg) |-> $past(pend)) else $error("irq rose without enabled cause");
  AST_FORCE_SETS: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
    (wr_go && awaddr_reg == `ITMS_OFF_CAUSE_FORCE && wstrb_reg == 4'hF)
    |=> ((cause_reg & $past(wdata_reg) & `ITMS_CAUSE_VALID_MASK)
         == ($past(wdata_reg) & `ITMS_CAUSE_VALID_MASK))) else $error("force lost");
  AST_SET_KEEPS: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
    (wr_go && awaddr_reg == `ITMS_OFF_ENABLE_SET && !rd_go)
    |=> (enable_reg == $past(enable_reg | (wval & `ITMS_CAUSE_VALID_MASK)))) else $error("enable set wrong");
  AST_CLEAR_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE19]
    (wr_go && awaddr_reg == `ITMS_OFF_ENABLE_CLEAR && wstrb_reg == 4'hF)
    |=> ((enable_reg & $past(wdata_reg)) == `ITMS_ZERO32)) else $error("enable clear failed");
  AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
    (cause_reg & ~`ITMS_CAUSE_VALID_MASK) == `ITMS_ZERO32) else $error("reserved cause bit set");
  AST_ZERO_NO_THROTTLE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    (fire_seq and interval_reg == 16'h0000) |=> state_reg == ITMS_IDLE) else $error("zero interval throttled");
  AST_SPACING: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
    (state_reg == ITMS_HOLD && elapsed_reg < interval_reg && !tclr_reg) |=> state_reg != ITMS_FIRE)
    else $error("fired before interval");
  AST_FIRE_RAISES: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE20]
    fire_seq |=> irq_reg) else $error("fire without irq");
  AST_READ_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE18]
    (rd_go && s_axi_araddr == `ITMS_OFF_CAUSE_READ && enable_reg == `ITMS_ZERO32 && event_in == `ITMS_ZERO32 && !wr_go)
    |=> cause_reg == `ITMS_ZERO32) else $error("read did not clear");
endmodule
`default_nettype wire

// ---- bench/itms_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Host side: counts interrupts and timer-clear pulses
// ****************************************************************
module itms_host_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic host_irq,
  input wire logic delay_timers_clear,
  output var int rise_cnt,
  output var int last_gap,
  output var int clr_cnt
);
  int since;
  logic irq_d;
  // Cycles between rising edges; a level line, so edges mark new messages
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rise_cnt <= 0;
      last_gap <= 0;
      clr_cnt <= 0;
      since <= 0;
      irq_d <= 1'b0;
    end
    else
    begin
      irq_d <= host_irq;
      since <= since + 1;
      if (host_irq && !irq_d)
      begin
        rise_cnt <= rise_cnt + 1;
        last_gap <= since;
        since <= 1;
      end
      if (delay_timers_clear)
        clr_cnt <= clr_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/interrupt_throttle_mask_set_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "itms_map.svh"
module interrupt_throttle_mask_set_tb_top;
  import itms_pkg::*;
  localparam int TK = 2;
  localparam logic [31:0] SUM = 32'h8000_0000;
  logic aclk;
  logic aresetn;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, host_irq, dtc;
  logic [31:0] wdata, event_in, exp;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  itms_word_t rdata, rd;
  int error_cnt, checks, rise_cnt, last_gap, clr_cnt, c0;
  int bits[13] = '{0, 1, 2, 4, 6, 7, 9, 15, 16, 17, 20, 22, 24};

  itms_top #(.TICK_CYCLES(TK)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .event_in(event_in), .host_irq(host_irq), .delay_timers_clear(dtc));
  itms_host_model host (.aclk(aclk), .aresetn(aresetn), .host_irq(host_irq), .delay_timers_clear(dtc),
    .rise_cnt(rise_cnt), .last_gap(last_gap), .clr_cnt(clr_cnt));

  // Clock, 5 ns period
  always #2.5 aclk = ~aclk;

  // ****************************************************************
  // Compare, bus and wait tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    checks++;
    if (got !== want)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, want);
    end
  endtask

  task automatic chk_bit(input logic got, input logic want, input string what);
    checks++;
    if (got !== want)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %b", $time, what, got);
    end
  endtask

  // Write: both halves offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
    // Extra edge so the next call never re-drives in the same step
    @(posedge aclk);
  endtask

  task automatic rdw(input logic [11:0] a);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rd = rdata;
        rs = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (host_irq !== lvl && n < 300)
    begin
      @(posedge aclk);
      n++;
    end
    chk_bit(host_irq, lvl, "irq level");
  endtask

  // One forced interrupt, then acknowledged through the cause register
  task automatic irq_cycle();
    wr(`ITMS_OFF_CAUSE_FORCE, 32'h0000_0001);
    wait_irq(1'b1);
    wr(`ITMS_OFF_CAUSE_READ, 32'h0000_0001);
    wait_irq(1'b0);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    summarize();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb, event_in} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    error_cnt = 0;
    checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, write-only and unmapped places
    rdw(`ITMS_OFF_MIN_INTERVAL);
    chk(rd, 32'h0, "interval reset");
    chk({30'h0, rs}, 32'h0, "mapped read resp");
    rdw(`ITMS_OFF_ENABLE_SET);
    chk(rd, 32'h0, "enable reset");
    rdw(`ITMS_OFF_CAUSE_FORCE);
    chk(rd, 32'h0, "force reads zero");
    rdw(12'h100);
    chk({30'h0, rs}, 32'h2, "unmapped read resp");
    chk(rd, 32'h0, "unmapped data");
    wr(12'h100, 32'h1);
    chk({30'h0, rs}, 32'h2, "unmapped write resp");
    chk_bit(host_irq, 1'b0, "irq after reset");
    // Full 16-bit interval, reserved upper bits kept zero by software
    wr(`ITMS_OFF_MIN_INTERVAL, 32'h0000_FFFF);
    chk({30'h0, rs}, 32'h0, "mapped write resp");
    rdw(`ITMS_OFF_MIN_INTERVAL);
    chk(rd, 32'h0000_FFFF, "interval width");
    // Start of the suggested tuning range
    wr(`ITMS_OFF_MIN_INTERVAL, 32'h0000_028B);
    rdw(`ITMS_OFF_MIN_INTERVAL);
    chk(rd, 32'h0000_028B, "interval value");
    wr(`ITMS_OFF_MIN_INTERVAL, 32'h0);
    // Enable set: ones set, zeros keep, strobes honoured
    wr(`ITMS_OFF_ENABLE_SET, 32'h5);
    wr(`ITMS_OFF_ENABLE_SET, 32'h0);
    rdw(`ITMS_OFF_ENABLE_SET);
    chk(rd, 32'h5, "enable keep");
    wr(`ITMS_OFF_ENABLE_SET, 32'hFFFF_FFFF, 4'h1);
    rdw(`ITMS_OFF_ENABLE_SET);
    chk(rd, 32'hD7, "enable strobe");
    // All-ones write clears timers only with the control bit set
    c0 = clr_cnt;
    wr(`ITMS_OFF_ENABLE_SET, 32'hFFFF_FFFF);
    chk(clr_cnt - c0, 32'h0, "no timer clear");
    wr(`ITMS_OFF_EXT_CONTROL, 32'h2);
    wr(`ITMS_OFF_ENABLE_SET, 32'hFFFF_FFFE);
    wr(`ITMS_OFF_ENABLE_SET, 32'hFFFF_FFFF);
    chk(clr_cnt - c0, 32'h1, "timer clear pulse");
    wr(`ITMS_OFF_EXT_CONTROL, 32'h0);
    rdw(`ITMS_OFF_ENABLE_SET);
    chk(rd, `ITMS_CAUSE_VALID_MASK, "enable map");
    // Disable only through the clear register
    wr(`ITMS_OFF_ENABLE_CLEAR, 32'hFFFF_FFFF);
    rdw(`ITMS_OFF_ENABLE_SET);
    chk(rd, 32'h0, "enable clear");
    // Every cause position forced; masks zero so each read clears
    foreach (bits[i])
    begin
      exp = SUM | (32'h1 << bits[i]);
      if ((exp & `ITMS_OTHER_SRC_MASK) != 0)
        exp = exp | 32'h0100_0000;
      wr(`ITMS_OFF_CAUSE_FORCE, 32'h1 << bits[i]);
      rdw(`ITMS_OFF_CAUSE_READ);
      chk(rd, exp, "forced cause");
    end
    rdw(`ITMS_OFF_CAUSE_READ);
    chk(rd, 32'h0, "read cleared");
    wr(`ITMS_OFF_CAUSE_FORCE, 32'h8);
    rdw(`ITMS_OFF_CAUSE_READ);
    chk(rd, 32'h0, "reserved cause");
    // Event input for one cycle
    event_in <= 32'h10;
    @(posedge aclk);
    event_in <= 32'h0;
    @(posedge aclk);
    rdw(`ITMS_OFF_CAUSE_READ);
    chk(rd, SUM | 32'h10, "event cause");
    // Only an enabled cause interrupts
    wr(`ITMS_OFF_ENABLE_SET, 32'h80);
    wr(`ITMS_OFF_CAUSE_FORCE, 32'h1);
    repeat (10) @(posedge aclk);
    chk_bit(host_irq, 1'b0, "masked cause");
    wr(`ITMS_OFF_CAUSE_FORCE, 32'h80);
    wait_irq(1'b1);
    wr(`ITMS_OFF_CAUSE_READ, 32'h1);
    rdw(`ITMS_OFF_CAUSE_READ);
    chk(rd, SUM | 32'h80, "w1c keeps others");
    chk_bit(host_irq, 1'b1, "irq held");
    wr(`ITMS_OFF_CAUSE_READ, 32'h80);
    wait_irq(1'b0);
    rdw(`ITMS_OFF_CAUSE_READ);
    chk(rd, 32'h0, "summary cleared");
    wr(`ITMS_OFF_ENABLE_CLEAR, 32'h80);
    // Throttle off: interrupts come back to back
    wr(`ITMS_OFF_ENABLE_SET, 32'h1);
    irq_cycle();
    irq_cycle();
    chk_bit(last_gap <= 20, 1'b1, "unthrottled gap");
    // Throttle of 20 ticks: no sooner, and fired at expiry
    wr(`ITMS_OFF_MIN_INTERVAL, 32'd20);
    irq_cycle();
    irq_cycle();
    chk_bit(last_gap >= 20 * TK, 1'b1, "min spacing");
    chk_bit(last_gap <= 20 * TK + 8, 1'b1, "fire at expiry");
    // Auto-mask applied by reading an asserted cause
    wr(`ITMS_OFF_EXT_CONTROL, 32'h1);
    wr(`ITMS_OFF_AUTO_MASK, 32'h1);
    wr(`ITMS_OFF_CAUSE_FORCE, 32'h1);
    wait_irq(1'b1);
    rdw(`ITMS_OFF_CAUSE_READ);
    chk(rd, SUM | 32'h1, "asserted cause");
    rdw(`ITMS_OFF_ENABLE_SET);
    chk(rd, 32'h0, "auto mask");
    rdw(`ITMS_OFF_CAUSE_READ);
    chk(rd, 32'h0, "auto cleared");
    summarize();
  end
endmodule
`default_nettype wire
